// ===== rwtc_pkg.sv
`default_nettype none
package rwtc_pkg;
    // Register word addresses.
    localparam logic [3:0] ADDR_CONTROL_FIRST  = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_SECOND = 4'h1;
    localparam logic [3:0] ADDR_CONTROL_THIRD  = 4'h2;
    localparam logic [3:0] ADDR_COMMAND        = 4'h3;
    localparam logic [3:0] ADDR_STATUS         = 4'h4;
    localparam logic [3:0] ADDR_A_RISE         = 4'h5;
    localparam logic [3:0] ADDR_A_FALL         = 4'h6;
    localparam logic [3:0] ADDR_B_RISE         = 4'h7;
    localparam logic [3:0] ADDR_B_FALL_LOW     = 4'h8;
    localparam logic [3:0] ADDR_B_FALL_HIGH    = 4'h9;
    localparam logic [3:0] ADDR_FAULT_CONFIG   = 4'hA;
    localparam logic [3:0] ADDR_UNLOCK         = 4'hB;
    localparam logic [3:0] ADDR_COUNT          = 4'hC;
    // Field positions.
    localparam int BIT_ENABLE      = 0;
    localparam int BIT_AUTO        = 0;
    localparam int BIT_SYNC_EOC    = 0;
    localparam int BIT_SYNC_NOW    = 1;
    localparam int BIT_RESTART     = 2;
    localparam int BIT_EN_READY    = 0;
    localparam int BIT_CMD_READY   = 1;
    localparam int BIT_BUF_READY   = 2;
    localparam int BIT_RUNNING     = 3;
    // Reset values.
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam logic [11:0] RESET_COMPARE = 12'h000;
    // Unlock key and window for the protected fault register.
    localparam logic [7:0] UNLOCK_KEY    = 8'hD8;
    localparam int         UNLOCK_CYCLES = 4;

    typedef enum logic [1:0] {
        RWTC_ONE_RAMP  = 2'h0,
        RWTC_TWO_RAMP  = 2'h1,
        RWTC_FOUR_RAMP = 2'h2,
        RWTC_DUAL      = 2'h3
    } rwtc_scheme_t;

    // Gray sequence dead A, on A, dead B, on B.
    typedef enum logic [1:0] {
        RWTC_DEAD_A = 2'b00,
        RWTC_ON_A   = 2'b01,
        RWTC_DEAD_B = 2'b11,
        RWTC_ON_B   = 2'b10
    } rwtc_state_t;

    typedef struct packed {
        logic [11:0] a_rise_value;
        logic [11:0] a_fall_value;
        logic [11:0] b_rise_value;
        logic [11:0] b_fall_value;
    } rwtc_compare_t;

    typedef struct packed {
        logic wave_out_a;
        logic wave_out_b;
    } rwtc_wave_t;
endpackage
`default_nettype wire

// ===== rwtc_core.sv
// What this block does
// - Each one, two and four ramp cycle walks dead A, on A, dead B, on B, each ended by its compare; dual slope stays in dead A.
// - One ramp counts zero to B fall, then restarts; period B fall plus one.
// - One ramp clears outputs at B fall; later compares and inverted A fall ignored.
// - Two ramp counts to A fall, resets, counts to B fall; period sum plus two.
// - Two ramp never reaches a rise above its fall; outputs never overlap.
// - Four ramp counts to each compare in turn, resetting after each.
// - Dual slope counts down from B fall to zero and back; period twice B fall plus two.
// - Dual slope raises A on down-count match of A rise, lowers on up-count match.
// - Dual slope raises B on up-count match of B rise, lowers on down-count match.
// - Dual slope ignores the A fall value completely.
// - Scheme is chosen by the waveform scheme field of the second control register.
// - Enable may change only while enable ready reads one.
// - Other first control bits are locked while enabled.
// - Command register is a self-clearing strobe, sent when enabled and idle.
// - Buffered compares take writes only when ready; copied on sync or enable.
// - Auto transfer makes each B fall high write transfer at cycle end.
// - Immediate sync transfers at once, end sync at next cycle end; ignored if pending.
// - Static registers do not update while enabled.
// - Status and normal registers are accessible at any time.
// - Fault config changes only through the timed unlock-then-write sequence.
// - Dual slope starts at B fall counting down; B waits for first up match.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rwtc_core #(
    parameter int CNT_W   = 12,
    parameter int PRESC_W = 4
) (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic [3:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic [7:0]              rdata_o,
    output rwtc_pkg::rwtc_wave_t    wave_o,
    output logic                    wave_out_a_o,
    output logic                    wave_out_b_o
);
    import rwtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]         control_first;
    logic [7:0]         control_second;
    logic [7:0]         control_third;
    logic [7:0]         fault_config;
    logic               enable;
    rwtc_compare_t      buf_cmp;
    rwtc_compare_t      act_cmp;
    logic [7:0]         b_fall_low_shadow;
    logic               cmd_pending;
    logic [1:0]         pending_kind;
    logic               en_busy;
    logic [2:0]         unlock_cnt;
    logic [PRESC_W-1:0] presc_cnt;
    logic               cnt_tick;
    logic [CNT_W-1:0]   count;
    logic               count_down;
    rwtc_state_t        state;
    logic               cycle_end;
    logic               wave_a;
    logic               wave_b;
    logic               first_cycle;
    rwtc_scheme_t       scheme;
    logic               wr_ctrl1;
    logic               buf_ok;

    assign scheme   = rwtc_scheme_t'(control_second[1:0]);
    assign wr_ctrl1 = wr_i && addr_i == ADDR_CONTROL_FIRST;
    // Buffered writes need no pending transfer while running.
    assign buf_ok   = !enable || !cmd_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Enable changes take one cycle to settle; ready is low meanwhile.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            enable        <= 1'b0;
            en_busy       <= 1'b0;
            control_first <= RESET_BYTE;
        end else begin
            en_busy <= 1'b0;
            if (wr_ctrl1 && !en_busy) begin
                enable  <= wdata_i[BIT_ENABLE];
                en_busy <= wdata_i[BIT_ENABLE] != enable;
                if (!enable) begin
                    control_first <= wdata_i & 8'hFE;
                end
            end
        end
    end

    // Static configuration only while stopped.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            control_second <= RESET_BYTE;
            control_third  <= RESET_BYTE;
        end else if (wr_i && !enable) begin
            if (addr_i == ADDR_CONTROL_SECOND) begin
                control_second <= wdata_i;
            end
            if (addr_i == ADDR_CONTROL_THIRD) begin
                control_third <= wdata_i;
            end
        end
    end

    // Key write opens a short window; only then may fault config change.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            unlock_cnt   <= 3'h0;
            fault_config <= RESET_BYTE;
        end else begin
            if (wr_i && addr_i == ADDR_UNLOCK && wdata_i == UNLOCK_KEY) begin
                unlock_cnt <= 3'(UNLOCK_CYCLES);
            end else if (unlock_cnt != 3'h0) begin
                unlock_cnt <= unlock_cnt - 3'h1;
            end
            if (wr_i && addr_i == ADDR_FAULT_CONFIG && unlock_cnt != 3'h0 && !enable) begin
                fault_config <= wdata_i;
                unlock_cnt   <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            buf_cmp           <= '0;
            b_fall_low_shadow <= RESET_BYTE;
        end else if (wr_i && buf_ok) begin
            case (addr_i)
                ADDR_A_RISE:      buf_cmp.a_rise_value <= {buf_cmp.a_rise_value[11:8], wdata_i};
                ADDR_A_FALL:      buf_cmp.a_fall_value <= {buf_cmp.a_fall_value[11:8], wdata_i};
                ADDR_B_RISE:      buf_cmp.b_rise_value <= {buf_cmp.b_rise_value[11:8], wdata_i};
                ADDR_B_FALL_LOW:  b_fall_low_shadow    <= wdata_i;
                ADDR_B_FALL_HIGH: buf_cmp.b_fall_value <= {wdata_i[3:0], b_fall_low_shadow};
                default: begin
                end
            endcase
        end
    end

    // Command strobe: held pending until the counter side consumes it.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cmd_pending  <= 1'b0;
            pending_kind <= 2'h0;
            act_cmp      <= '0;
        end else begin
            if (!enable) begin
                act_cmp     <= buf_cmp;
                cmd_pending <= 1'b0;
            end else if (cmd_pending) begin
                if (pending_kind[BIT_SYNC_NOW] || (cycle_end && cnt_tick)) begin
                    act_cmp      <= buf_cmp;
                    cmd_pending  <= 1'b0;
                end
            end else if (wr_i && addr_i == ADDR_COMMAND) begin
                cmd_pending  <= wdata_i[BIT_SYNC_NOW] | wdata_i[BIT_SYNC_EOC];
                pending_kind <= wdata_i[1:0];
            end else if (wr_i && addr_i == ADDR_B_FALL_HIGH && control_third[BIT_AUTO]) begin
                cmd_pending  <= 1'b1;
                pending_kind <= 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter clock enable from a divider of the system clock.
    always_ff @(posedge clock_i) begin
        // Restarting on each tick makes the tick period the prescale setting plus one.
        if (rst_i || !enable || cnt_tick) begin
            presc_cnt <= '0;
        end else begin
            presc_cnt <= presc_cnt + PRESC_W'(1);
        end
    end
    assign cnt_tick = enable && presc_cnt == PRESC_W'(control_first[7:4]);

    // End of the current ramp.
    logic [CNT_W-1:0] limit;
    always_comb begin
        limit = act_cmp.b_fall_value;
        case (scheme)
            RWTC_TWO_RAMP:  limit = (state == RWTC_DEAD_A || state == RWTC_ON_A) ? act_cmp.a_fall_value
                                                                             : act_cmp.b_fall_value;
            RWTC_FOUR_RAMP: begin
                case (state)
                    RWTC_DEAD_A: limit = act_cmp.a_rise_value;
                    RWTC_ON_A:   limit = act_cmp.a_fall_value;
                    RWTC_DEAD_B: limit = act_cmp.b_rise_value;
                    default:     limit = act_cmp.b_fall_value;
                endcase
            end
            default: limit = act_cmp.b_fall_value;
        endcase
    end

    assign cycle_end = (scheme == RWTC_DUAL) ? (!count_down && count == act_cmp.b_fall_value)
                     : (scheme == RWTC_ONE_RAMP) ? count == act_cmp.b_fall_value
                     : (count == limit && state == RWTC_ON_B);

    always_ff @(posedge clock_i) begin
        if (rst_i || !enable) begin
            count       <= (scheme == RWTC_DUAL) ? buf_cmp.b_fall_value : '0;
            count_down  <= 1'b1;
            state       <= RWTC_DEAD_A;
            first_cycle <= 1'b1;
        end else if (cnt_tick) begin
            case (scheme)
                RWTC_ONE_RAMP: begin
                    count <= cycle_end ? '0 : count + CNT_W'(1);
                    if (cycle_end) state <= RWTC_DEAD_A;
                    else if (count == act_cmp.a_rise_value) state <= RWTC_ON_A;
                    else if (count == act_cmp.a_fall_value && state == RWTC_ON_A) state <= RWTC_DEAD_B;
                    else if (count == act_cmp.b_rise_value) state <= RWTC_ON_B;
                end
                RWTC_TWO_RAMP: begin
                    if (count == limit) begin
                        count <= '0;
                        state <= (state == RWTC_DEAD_A || state == RWTC_ON_A) ? RWTC_DEAD_B : RWTC_DEAD_A;
                    end else begin
                        count <= count + CNT_W'(1);
                        if (state == RWTC_DEAD_A && count == act_cmp.a_rise_value) state <= RWTC_ON_A;
                        if (state == RWTC_DEAD_B && count == act_cmp.b_rise_value) state <= RWTC_ON_B;
                    end
                end
                RWTC_FOUR_RAMP: begin
                    if (count == limit) begin
                        count <= '0;
                        case (state)
                            RWTC_DEAD_A: state <= RWTC_ON_A;
                            RWTC_ON_A:   state <= RWTC_DEAD_B;
                            RWTC_DEAD_B: state <= RWTC_ON_B;
                            default:     state <= RWTC_DEAD_A;
                        endcase
                    end else begin
                        count <= count + CNT_W'(1);
                    end
                end
                default: begin
                    if (count_down) begin
                        if (count == '0) count_down <= 1'b0;
                        else count <= count - CNT_W'(1);
                    end else if (cycle_end) begin
                        count_down  <= 1'b1;
                        first_cycle <= 1'b0;
                    end else begin
                        count <= count + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs are registered from the matches of the current count, or from the state in two and four ramp.
    always_ff @(posedge clock_i) begin
        if (rst_i || !enable) begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else if (cnt_tick) begin
            case (scheme)
                RWTC_ONE_RAMP: begin
                    if (cycle_end) begin
                        wave_a <= 1'b0;
                        wave_b <= 1'b0;
                    end else begin
                        if (count == act_cmp.a_rise_value) wave_a <= 1'b1;
                        else if (count == act_cmp.a_fall_value && act_cmp.a_fall_value > act_cmp.a_rise_value)
                            wave_a <= 1'b0;
                        if (count == act_cmp.b_rise_value) wave_b <= 1'b1;
                    end
                end
                RWTC_DUAL: begin
                    if (count == act_cmp.a_rise_value) wave_a <= count_down;
                    if (count == act_cmp.b_rise_value && !(count_down && first_cycle))
                        wave_b <= !count_down;
                end
                default: begin
                    wave_a <= state == RWTC_ON_A;
                    wave_b <= state == RWTC_ON_B;
                end
            endcase
        end
    end

    assign wave_o       = '{wave_out_a: wave_a, wave_out_b: wave_b};
    assign wave_out_a_o = wave_a;
    assign wave_out_b_o = wave_b;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_CONTROL_FIRST:  rdata_o <= control_first | {7'h00, enable};
                ADDR_CONTROL_SECOND: rdata_o <= control_second;
                ADDR_CONTROL_THIRD:  rdata_o <= control_third;
                ADDR_STATUS:         rdata_o <= {4'h0, enable, buf_ok, !cmd_pending, !en_busy};
                ADDR_A_RISE:         rdata_o <= buf_cmp.a_rise_value[7:0];
                ADDR_A_FALL:         rdata_o <= buf_cmp.a_fall_value[7:0];
                ADDR_B_RISE:         rdata_o <= buf_cmp.b_rise_value[7:0];
                ADDR_B_FALL_LOW:     rdata_o <= buf_cmp.b_fall_value[7:0];
                ADDR_B_FALL_HIGH:    rdata_o <= {4'h0, buf_cmp.b_fall_value[11:8]};
                ADDR_FAULT_CONFIG:   rdata_o <= fault_config;
                ADDR_COUNT:          rdata_o <= count[7:0];
                default:             rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== rwtc_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rwtc_core_asserts #(
    parameter int CNT_W   = 12,
    parameter int PRESC_W = 4
) (
    input wire logic                 clock_i,
    input wire logic                 rst_i,
    input wire logic [3:0]           addr_i,
    input wire logic [7:0]           wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire rwtc_pkg::rwtc_wave_t wave_o,
    input wire logic                 wave_out_a_o,
    input wire logic                 wave_out_b_o
);
    import rwtc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of what software has been allowed to change; the busy bit mirrors
    // the one-cycle enable handshake so a refused enable write is not tracked.
    logic       busy;
    logic       en_sh;
    logic       ever_en;
    logic       key_seen;
    logic [1:0] scheme_sh;
    logic [3:0] presc_sh;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy     <= 1'b0;
            en_sh    <= 1'b0;
            presc_sh <= 4'h0;
        end else if (wr_i && addr_i == ADDR_CONTROL_FIRST && !busy) begin
            busy  <= wdata_i[BIT_ENABLE] != en_sh;
            en_sh <= wdata_i[BIT_ENABLE];
            if (!en_sh) begin
                presc_sh <= wdata_i[7:4];
            end
        end else begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            scheme_sh <= 2'h0;
        end else if (wr_i && addr_i == ADDR_CONTROL_SECOND && !en_sh) begin
            scheme_sh <= wdata_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            key_seen <= 1'b0;
            ever_en  <= 1'b0;
        end else begin
            key_seen <= key_seen | (wr_i && addr_i == ADDR_UNLOCK && wdata_i == UNLOCK_KEY);
            ever_en  <= ever_en | en_sh;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence rd_at(logic [3:0] a);
        rd_i && addr_i == a;
    endsequence

    sequence ramp_run;
        (en_sh && (scheme_sh == RWTC_TWO_RAMP || scheme_sh == RWTC_FOUR_RAMP))[*3];
    endsequence

    AST_RESET_QUIET: assert property (@(posedge clock_i) disable iff (1'b0)
        rst_i |=> rdata_o == 8'h00 && !wave_out_a_o && !wave_out_b_o) else $error("outputs not cleared by reset");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data without read");
    AST_CTRL1_LOCK: assert property (rd_at(ADDR_CONTROL_FIRST) |=>
        {rdata_o[7:4], rdata_o[0]} == $past({presc_sh, en_sh})) else $error("first control value wrong");
    AST_CTRL2_HOLD: assert property (rd_at(ADDR_CONTROL_SECOND) |=>
        rdata_o[1:0] == $past(scheme_sh)) else $error("scheme changed while enabled");
    AST_FAULT_LOCKED: assert property (rd_at(ADDR_FAULT_CONFIG) ##0 !key_seen |=>
        rdata_o == RESET_BYTE) else $error("fault setting changed without unlock");
    AST_MIRROR_A: assert property (wave_o.wave_out_a == wave_out_a_o) else $error("output A copies differ");
    AST_MIRROR_B: assert property (wave_o.wave_out_b == wave_out_b_o) else $error("output B copies differ");
    AST_IDLE_QUIET: assert property (!ever_en |-> !wave_out_a_o && !wave_out_b_o) else $error("output before enable");
    AST_NO_OVERLAP: assert property (ramp_run |-> !(wave_out_a_o && wave_out_b_o)) else $error("outputs overlap");
endmodule

bind rwtc_core rwtc_core_asserts #(.CNT_W(CNT_W), .PRESC_W(PRESC_W)) rwtc_core_asserts_inst (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .wave_o(wave_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o));
`default_nettype wire

// ===== rwtc_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rwtc_core_tb;
    import rwtc_pkg::*;
    logic              clock_i;
    logic              rst_i;
    logic [3:0]        addr_i;
    logic [7:0]        wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic              chk_tag;
    logic              chk_d;
    logic [7:0]        rdata_o;
    rwtc_wave_t        wave_o;
    logic              wave_out_a_o;
    logic              wave_out_b_o;
    logic [7:0]        exp_q[$];
    int                num_errors;
    int                num_checks;
    int                ar, af, br, bf, per, wid, p;

    rwtc_core #(.CNT_W(12), .PRESC_W(4)) rwtc_core_inst (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .wave_o(wave_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus cycle per call, so consecutive calls give back-to-back strobes.
    task cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d, input logic c);
        @(posedge clock_i);
        wr_i    <= w;
        rd_i    <= r;
        addr_i  <= a;
        wdata_i <= d;
        chk_tag <= c;
        if (c) exp_q.push_back(d);
    endtask

    always @(posedge clock_i) chk_d <= rd_i & chk_tag;
    always @(negedge clock_i) if (chk_d) check({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});

    task wait_ready;
        int  i;
        logic ok;
        ok = 1'b0;
        for (i = 0; i < 50 && !ok; i++) begin
            cyc(1'b0, 1'b1, ADDR_STATUS, 8'h00, 1'b0);
            cyc(1'b0, 1'b0, ADDR_STATUS, 8'h00, 1'b0);
            @(negedge clock_i);
            ok = (rdata_o[BIT_EN_READY] === 1'b1);
        end
        if (!ok) begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Times from the second rise of output A, skipping the start-up cycle.
    task meas(input int pr, input int wd);
        int   t, n, cnt, hw;
        logic pa;
        n = 0; cnt = 0; hw = 0;
        pa = wave_out_a_o;
        for (t = 0; t < 4000 && n < 3; t++) begin
            @(negedge clock_i);
            if (n == 2) begin
                cnt++;
                if (wave_out_a_o === 1'b1 && pa === 1'b0) n = 3;
                else if (wave_out_a_o === 1'b1) hw++;
            end else if (wave_out_a_o === 1'b1 && pa === 1'b0) begin
                n++;
                hw = 1;
            end
            pa = wave_out_a_o;
        end
        if (n < 3) begin
            num_errors++;
            report_and_stop();
        end
        check(cnt[15:0], pr[15:0]);
        if (wd >= 0) check(hw[15:0], wd[15:0]);
    endtask

    task run(input logic [1:0] s);
        wait_ready();
        cyc(1'b1, 1'b0, ADDR_CONTROL_FIRST, 8'h00, 1'b0);
        cyc(1'b0, 1'b0, ADDR_CONTROL_FIRST, 8'h00, 1'b0);
        wait_ready();
        cyc(1'b1, 1'b0, ADDR_CONTROL_SECOND, {6'h00, s}, 1'b0);
        cyc(1'b1, 1'b0, ADDR_CONTROL_THIRD, 8'h01, 1'b0);
        cyc(1'b1, 1'b0, ADDR_A_RISE, ar[7:0], 1'b0);
        cyc(1'b1, 1'b0, ADDR_A_FALL, af[7:0], 1'b0);
        cyc(1'b1, 1'b0, ADDR_B_RISE, br[7:0], 1'b0);
        cyc(1'b1, 1'b0, ADDR_B_FALL_LOW, bf[7:0], 1'b0);
        cyc(1'b1, 1'b0, ADDR_B_FALL_HIGH, 8'h00, 1'b0);
        cyc(1'b1, 1'b0, ADDR_CONTROL_FIRST, {p[3:0], 4'h1}, 1'b0);
        cyc(1'b1, 1'b0, ADDR_CONTROL_FIRST, 8'h00, 1'b0);
        cyc(1'b1, 1'b0, ADDR_CONTROL_SECOND, {6'h00, ~s}, 1'b0);
        cyc(1'b1, 1'b0, ADDR_CONTROL_FIRST, 8'hF1, 1'b0);
        cyc(1'b0, 1'b1, ADDR_CONTROL_FIRST, {p[3:0], 4'h1}, 1'b1);
        cyc(1'b0, 1'b1, ADDR_CONTROL_SECOND, {6'h00, s}, 1'b1);
        cyc(1'b0, 1'b0, ADDR_STATUS, 8'h00, 1'b0);
        meas(per * (p + 1), (wid < 0) ? -1 : wid * (p + 1));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0; num_checks = 0;
        rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; chk_tag = 1'b0;
        addr_i = 4'h0; wdata_i = 8'h00;
        void'($urandom(32'h29B6));
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        cyc(1'b0, 1'b1, ADDR_CONTROL_FIRST, RESET_BYTE, 1'b1);
        cyc(1'b0, 1'b1, 4'hF, 8'h00, 1'b1);
        cyc(1'b1, 1'b0, ADDR_FAULT_CONFIG, 8'h55, 1'b0);
        cyc(1'b0, 1'b1, ADDR_FAULT_CONFIG, RESET_BYTE, 1'b1);
        cyc(1'b1, 1'b0, ADDR_UNLOCK, UNLOCK_KEY, 1'b0);
        cyc(1'b1, 1'b0, ADDR_FAULT_CONFIG, 8'h3C, 1'b0);
        cyc(1'b0, 1'b1, ADDR_FAULT_CONFIG, 8'h3C, 1'b1);
        for (int s = 0; s < 4; s++) begin
            p  = $urandom % 3;
            ar = 1 + $urandom % 4;
            af = ar + 2 + $urandom % 6;
            br = af + 1 + $urandom % 4;
            bf = br + 2 + $urandom % 8;
            wid = (s < 2) ? af - ar : -1;
            case (s)
                0: per = bf + 1;
                1: per = af + bf + 2;
                2: per = ar + af + br + bf + 4;
                default: per = 2 * (bf + 1);
            endcase
            if (s == 3) af = $urandom % ar;
            run(s[1:0]);
        end
        p = 1; ar = 6; af = 2; br = 8; bf = 12; per = 13; wid = 6;
        run(RWTC_ONE_RAMP);
        // Running buffer update: immediate sync, then an automatic end-of-cycle transfer.
        cyc(1'b1, 1'b0, ADDR_A_RISE, 8'h03, 1'b0);
        cyc(1'b1, 1'b0, ADDR_COMMAND, 8'h02, 1'b0);
        cyc(1'b0, 1'b1, ADDR_STATUS, 8'h09, 1'b1);
        cyc(1'b0, 1'b1, ADDR_STATUS, 8'h0F, 1'b1);
        cyc(1'b0, 1'b1, ADDR_A_RISE, 8'h03, 1'b1);
        cyc(1'b0, 1'b0, ADDR_STATUS, 8'h00, 1'b0);
        meas(26, 18);
        cyc(1'b1, 1'b0, ADDR_B_FALL_LOW, 8'h0E, 1'b0);
        cyc(1'b1, 1'b0, ADDR_B_FALL_HIGH, 8'h00, 1'b0);
        cyc(1'b0, 1'b1, ADDR_STATUS, 8'h09, 1'b1);
        cyc(1'b0, 1'b0, ADDR_STATUS, 8'h00, 1'b0);
        meas(30, 22);
        report_and_stop();
    end
endmodule
`default_nettype wire
